// file: card_regs_pkg.sv
// Package with register map, field layout and fixed values of the card register bank.
package card_regs_pkg;

	// Avalon-MM register byte addresses.
	localparam logic [4:0] ADDR_REL_ADDR  = 5'h00;
	localparam logic [4:0] ADDR_DRV_STAGE = 5'h04;
	localparam logic [4:0] ADDR_FEAT_LO   = 5'h08;
	localparam logic [4:0] ADDR_FEAT_HI   = 5'h0c;
	localparam logic [4:0] ADDR_SPEC_FLAG = 5'h10;
	localparam logic [4:0] ADDR_STATUS    = 5'h14;
	localparam logic [4:0] ADDR_CONTROL   = 5'h18;

	// Reset values and the reserved zero address.
	localparam logic [15:0] REL_ADDR_RESET  = 16'h0000;
	localparam logic [15:0] DRV_STAGE_RESET = 16'h0404;
	localparam logic [15:0] REL_ADDR_ZERO   = 16'h0000;

	// Feature configuration field positions in the 64-bit word.
	localparam int FEAT_STRUCT_LSB = 60;
	localparam int SPEC_LSB        = 56;
	localparam int ERASE_DATA_BIT  = 55;
	localparam int SECURITY_LSB    = 52;
	localparam int BUS_WIDTHS_LSB  = 48;

	// Feature configuration field values.
	localparam logic [3:0] FEAT_STRUCT_V1_0   = 4'h0;
	localparam logic [3:0] SPEC_VERSION_VAL   = 4'h2;
	localparam logic       ERASE_DATA_VAL     = 1'b0;
	localparam logic [2:0] SECURITY_VAL       = 3'h2;
	localparam logic [3:0] BUS_WIDTHS_VAL     = 4'h5;
	localparam logic [47:0] FEAT_RESERVED_VAL = 48'h0000_0000_0000;

	// Specific-data flag word: driver stage implemented bit and its fixed value.
	localparam int   DRV_PRESENT_BIT = 0;
	localparam logic DRV_PRESENT_VAL = 1'b0;

	// Status and control bit positions.
	localparam int ST_IDENTIFIED = 0;
	localparam int ST_SELECTED   = 1;
	localparam int ST_LINK_READY = 2;
	localparam int ST_POWERED    = 3;
	localparam int CTL_PUBLISH   = 0;
	localparam int CTL_REVOKE    = 1;

	// Power-up bus clock count with the command line high.
	localparam logic [6:0] WARMUP_CLOCKS = 7'h4a;

	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Decoded command as handed over by the command path.
	typedef struct packed {
		logic        valid;
		logic        select;
		logic [15:0] addr;
	} card_cmd_t;

	// Answer of the address filter.
	typedef struct packed {
		logic accept;
		logic standby;
		logic selected;
	} addr_result_t;

	typedef enum logic [2:0] {
		PWR_OFF    = 3'b001,
		PWR_WARMUP = 3'b010,
		PWR_READY  = 3'b100
	} pwr_state_t;

endpackage

// file: pin_sync.sv
// Two flip-flop synchroniser for one asynchronous pin.
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset.
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	// Pin in and synchronised level out.
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			meta     <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// file: card_regs.sv
// Card register bank with relative address, driver stage, feature configuration and power-up tracking.
//
// Contract
// (RULE1) Hold a writable 16-bit relative address and publish it at identification.
// (RULE2) After identification accept addressed commands only when carrying our own address.
// (RULE3) Relative address resets to all zeros.
// (RULE4) Address zero is reserved: select with zero means stand-by; never publish zero.
// (RULE5) Hold a 16-bit driver stage register resetting to 0x404, optionally host-programmed.
// (RULE6) A specific-data flag tells whether the driver stage register is usable.
// (RULE7) The driver-stage-present flag reads zero: driver stage not implemented.
// (RULE8) Provide a 64-bit factory-fixed read-only feature configuration register.
// (RULE9) Layout: struct 63-60, spec 59-56, erase 55, security 54-52, widths 51-48, reserved.
// (RULE10) Structure version reads 0, meaning version 1.0; 1 to 15 never reported.
// (RULE11) Host gives 74 bus clocks with command high before the first command.
// (RULE12) Host keeps supply off at least 1 ms before powering up again; the bench host model keeps it off only OFF_NS, 2000 ns.
// (RULE13) Host drives lines low or releases them during power down.
// (RULE14) Host power-cycles on voltage change or to reach an inactive device.
// (RULE15) Every power cycle clears the address and demands a fresh identification.
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module card_regs
	import card_regs_pkg::*;
(
	// Clock and reset.
	input  wire logic         ref_clk_in,
	input  wire logic         rst_in,
	// Avalon-MM slave.
	input  wire logic [4:0]   avs_address_in,
	input  wire logic         avs_read_in,
	input  wire logic         avs_write_in,
	input  wire logic [31:0]  avs_writedata_in,
	input  wire logic [3:0]   avs_byteenable_in,
	output logic [31:0]       avs_readdata_out,
	output logic              avs_waitrequest_out,
	// Card pins, asynchronous to ref_clk_in.
	input  wire logic         power_good_in,
	input  wire logic         sd_clk_in,
	input  wire logic         sd_cmd_in,
	// Decoded commands from the command path.
	input  wire card_cmd_t    cmd_in,
	// Identification and address filter results, link ready and driver stage value.
	output logic [15:0]       published_addr_out,
	output logic              addr_published_out,
	output addr_result_t      addr_result_out,
	output logic              link_ready_out,
	output logic [15:0]       driver_stage_out
);

	logic        power_sync;
	logic        clk_sync;
	logic        cmd_sync;
	logic        clk_prev;
	logic        clk_rise;
	logic        ack;
	logic        bus_req;
	logic        wr_take;
	logic [15:0] relative_card_address;
	logic [15:0] driver_stage_control;
	logic        identified;
	logic        selected;
	logic [6:0]  warmup_count;
	logic [63:0] feature_configuration;
	logic [31:0] next_readdata;
	logic [31:0] status_word;
	pwr_state_t  pwr_state;

	pin_sync u_power_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (power_good_in),
		.sync_out   (power_sync)
	);

	pin_sync u_clk_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (sd_clk_in),
		.sync_out   (clk_sync)
	);

	pin_sync u_cmd_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   (sd_cmd_in),
		.sync_out   (cmd_sync)
	);

	// Bus clock edge detection works on the synchronised level only.
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= clk_sync;
		end
	end

	assign clk_rise = clk_sync & ~clk_prev;

	// Power tracking: warm-up counts bus clocks seen while the command line is high.
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pwr_state    <= PWR_OFF;
			warmup_count <= 7'h00;
		end else begin
			case (pwr_state)
				PWR_OFF: begin
					warmup_count <= 7'h00;
					if (power_sync) begin
						pwr_state <= PWR_WARMUP;
					end
				end
				PWR_WARMUP: begin
					if (!power_sync) begin
						pwr_state <= PWR_OFF;
					end else if (clk_rise && !cmd_sync) begin
						// A command started early; the count restarts rather than trusting a short warm-up.
						warmup_count <= 7'h00;
					end else if (clk_rise) begin
						warmup_count <= warmup_count + 7'h01;
						if (warmup_count + 7'h01 >= WARMUP_CLOCKS) begin // see (RULE11)
							pwr_state <= PWR_READY;
						end
					end
				end
				PWR_READY: begin
					if (!power_sync) begin
						pwr_state <= PWR_OFF; // see (RULE12)
					end
				end
				default: begin
					pwr_state <= PWR_OFF;
				end
			endcase
		end
	end

	assign link_ready_out = (pwr_state == PWR_READY);

	// Bus slave: one wait state for every access, so reads are registered.
	assign bus_req             = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = bus_req & ~ack;
	assign wr_take             = avs_write_in & ack;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ack <= 1'b0;
		end else begin
			ack <= bus_req & ~ack;
		end
	end

	// Relative address; only the low two byte lanes carry it.
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || pwr_state == PWR_OFF) begin
			relative_card_address <= REL_ADDR_RESET; // see (RULE3) see (RULE15)
		end else if (wr_take && avs_address_in == ADDR_REL_ADDR && !identified) begin
			if (avs_byteenable_in[0]) begin
				relative_card_address[7:0] <= avs_writedata_in[7:0]; // see (RULE1)
			end
			if (avs_byteenable_in[1]) begin
				relative_card_address[15:8] <= avs_writedata_in[15:8];
			end
		end
	end

	// Driver stage register is kept even though the flag says it is absent.
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			driver_stage_control <= DRV_STAGE_RESET; // see (RULE5)
		end else if (wr_take && avs_address_in == ADDR_DRV_STAGE) begin
			if (avs_byteenable_in[0]) begin
				driver_stage_control[7:0] <= avs_writedata_in[7:0];
			end
			if (avs_byteenable_in[1]) begin
				driver_stage_control[15:8] <= avs_writedata_in[15:8];
			end
		end
	end

	assign driver_stage_out = driver_stage_control;

	// Identification: publishing needs a ready link and a non-zero address.
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || pwr_state == PWR_OFF) begin
			identified <= 1'b0; // see (RULE15)
		end else if (wr_take && avs_address_in == ADDR_CONTROL && avs_byteenable_in[0]) begin
			if (avs_writedata_in[CTL_REVOKE]) begin
				identified <= 1'b0;
			end else if (avs_writedata_in[CTL_PUBLISH] && link_ready_out
					&& relative_card_address != REL_ADDR_ZERO) begin
				identified <= 1'b1; // see (RULE1) see (RULE4)
			end
		end
	end

	assign published_addr_out = identified ? relative_card_address : REL_ADDR_ZERO;
	assign addr_published_out = identified;

	// Address filter and select state: accept and standby after one cycle, the selected output one cycle later.
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || pwr_state == PWR_OFF) begin
			selected        <= 1'b0;
			addr_result_out <= '0;
		end else begin
			addr_result_out.accept  <= 1'b0;
			addr_result_out.standby <= 1'b0;
			if (cmd_in.valid && identified) begin
				if (cmd_in.select && cmd_in.addr == REL_ADDR_ZERO) begin
					selected                <= 1'b0; // see (RULE4)
					addr_result_out.standby <= 1'b1;
				end else if (cmd_in.addr == relative_card_address) begin
					addr_result_out.accept <= 1'b1; // see (RULE2)
					if (cmd_in.select) begin
						selected <= 1'b1;
					end
				end else if (cmd_in.select) begin
					selected <= 1'b0;
				end
			end
			addr_result_out.selected <= selected;
		end
	end

	// Factory-fixed feature configuration.
	always_comb begin
		feature_configuration                                = {16'h0000, FEAT_RESERVED_VAL}; // see (RULE8)
		feature_configuration[FEAT_STRUCT_LSB +: 4]          = FEAT_STRUCT_V1_0; // see (RULE10)
		feature_configuration[SPEC_LSB +: 4]                 = SPEC_VERSION_VAL; // see (RULE9)
		feature_configuration[ERASE_DATA_BIT]                = ERASE_DATA_VAL;
		feature_configuration[SECURITY_LSB +: 3]             = SECURITY_VAL;
		feature_configuration[BUS_WIDTHS_LSB +: 4]           = BUS_WIDTHS_VAL;
	end

	always_comb begin
		status_word                = READ_ZERO;
		status_word[ST_IDENTIFIED] = identified;
		status_word[ST_SELECTED]   = selected;
		status_word[ST_LINK_READY] = link_ready_out;
		status_word[ST_POWERED]    = power_sync;
	end

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		next_readdata = READ_ZERO;
		case (avs_address_in)
			ADDR_REL_ADDR:  next_readdata = {16'h0000, relative_card_address};
			ADDR_DRV_STAGE: next_readdata = {16'h0000, driver_stage_control};
			ADDR_FEAT_LO:   next_readdata = feature_configuration[31:0];
			ADDR_FEAT_HI:   next_readdata = feature_configuration[63:32];
			ADDR_SPEC_FLAG: next_readdata[DRV_PRESENT_BIT] = DRV_PRESENT_VAL; // see (RULE6) see (RULE7)
			ADDR_STATUS:    next_readdata = status_word;
			default:        next_readdata = READ_ZERO;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			avs_readdata_out <= READ_ZERO;
		end else if (avs_read_in && !ack) begin
			avs_readdata_out <= next_readdata;
		end
	end

endmodule

// file: card_regs_assertions.sv
// Concurrent checks on the card register bank ports.
`timescale 1ns/1ps
module card_regs_assertions
	import card_regs_pkg::*;
(
	// Watched ports.
	input  wire logic         ref_clk_in,
	input  wire logic         rst_in,
	input  wire logic [4:0]   avs_address_in,
	input  wire logic         avs_read_in,
	input  wire logic         avs_write_in,
	input  wire logic [31:0]  avs_readdata_out,
	input  wire logic         avs_waitrequest_out,
	input  wire logic         power_good_in,
	input  wire card_cmd_t    cmd_in,
	input  wire logic [15:0]  published_addr_out,
	input  wire logic         addr_published_out,
	input  wire addr_result_t addr_result_out,
	input  wire logic         link_ready_out,
	input  wire logic [15:0]  driver_stage_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	logic rd_done;
	logic hit;
	assign rd_done = avs_read_in && !avs_waitrequest_out;
	assign hit = cmd_in.valid && addr_published_out && cmd_in.addr == published_addr_out;
	property p_wait; $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out; endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	property p_addr_rst; $past(rst_in) |-> published_addr_out == 16'h0000 && !addr_published_out; endproperty
	a_addr_rst: assert property (p_addr_rst) else $error("address not zero after reset");
	property p_drv_rst; $past(rst_in) |-> driver_stage_out == 16'h0404; endproperty
	a_drv_rst: assert property (p_drv_rst) else $error("driver stage reset wrong");
	property p_no_zero; addr_published_out |-> published_addr_out != 16'h0000; endproperty
	a_no_zero: assert property (p_no_zero) else $error("zero address published");
	property p_accept; hit && cmd_in.select |=> addr_result_out.accept ##1 addr_result_out.selected; endproperty
	a_accept: assert property (p_accept) else $error("own address not accepted");
	property p_standby; cmd_in.valid && cmd_in.select && addr_published_out && cmd_in.addr == 16'h0000
		|=> addr_result_out.standby ##1 !addr_result_out.selected; endproperty
	a_standby: assert property (p_standby) else $error("zero select without stand-by");
	property p_unident; !addr_published_out |=> !addr_result_out.accept; endproperty
	a_unident: assert property (p_unident) else $error("accept while unidentified");
	property p_feat; rd_done && avs_address_in == ADDR_FEAT_HI |-> avs_readdata_out[31:28] == 4'h0; endproperty
	a_feat: assert property (p_feat) else $error("structure version wrong");
	property p_flag; rd_done && avs_address_in == ADDR_SPEC_FLAG |-> avs_readdata_out[0] == 1'b0; endproperty
	a_flag: assert property (p_flag) else $error("driver stage flag set");
	property p_power; !power_good_in [*6] |-> !link_ready_out && !addr_published_out; endproperty
	a_power: assert property (p_power) else $error("state kept over power loss");
	c_accept: cover property (addr_result_out.accept);
	c_standby: cover property (addr_result_out.standby);
	c_ready: cover property ($rose(link_ready_out));
endmodule

// file: sd_host_model.sv
// Host side of the card bus: supply, bus clock and command line.
`timescale 1ns/1ps
module sd_host_model #(parameter int OFF_NS = 2000) (
	// Card pins.
	output logic power_good_out,
	output logic sd_clk_out,
	output logic sd_cmd_out
);
	initial begin
		power_good_out = 1'b0;
		sd_clk_out = 1'b0;
		sd_cmd_out = 1'b0;
	end
	task automatic power_up(input int n);
		power_good_out = 1'b1;
		sd_cmd_out = 1'b1;
		#1003;
		repeat (n) begin // Clocks with the command line high
			#80 sd_clk_out = 1'b1;
			#80 sd_clk_out = 1'b0;
		end
	endtask
	task automatic power_down();
		power_good_out = 1'b0;
		sd_cmd_out = 1'b0; // Lines low so no current flows
		sd_clk_out = 1'b0;
		#(OFF_NS); // The off time is shortened to keep the run brief.
	endtask
endmodule

// file: test_card_regs.sv
// Self-checking bench for the card register bank.
`timescale 1ns/1ps
module test_card_regs
	import card_regs_pkg::*;
;
	localparam logic [63:0] FEAT_EXP = {4'h0, SPEC_VERSION_VAL, ERASE_DATA_VAL, SECURITY_VAL, BUS_WIDTHS_VAL, 48'h0};
	logic         ref_clk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic         power_good_in, sd_clk_in, sd_cmd_in, addr_published_out, link_ready_out;
	logic [4:0]   avs_address_in;
	logic [3:0]   avs_byteenable_in;
	logic [31:0]  avs_writedata_in, avs_readdata_out, rd, r32, seed;
	logic [15:0]  published_addr_out, driver_stage_out, addr, dsr;
	card_cmd_t    cmd_in;
	addr_result_t addr_result_out, res;
	int           num_errors, cmp_count;
	card_regs dut_u (
		.ref_clk_in          (ref_clk_in),
		.rst_in              (rst_in),
		.avs_address_in      (avs_address_in),
		.avs_read_in         (avs_read_in),
		.avs_write_in        (avs_write_in),
		.avs_writedata_in    (avs_writedata_in),
		.avs_byteenable_in   (avs_byteenable_in),
		.avs_readdata_out    (avs_readdata_out),
		.avs_waitrequest_out (avs_waitrequest_out),
		.power_good_in       (power_good_in),
		.sd_clk_in           (sd_clk_in),
		.sd_cmd_in           (sd_cmd_in),
		.cmd_in              (cmd_in),
		.published_addr_out  (published_addr_out),
		.addr_published_out  (addr_published_out),
		.addr_result_out     (addr_result_out),
		.link_ready_out      (link_ready_out),
		.driver_stage_out    (driver_stage_out)
	);
	sd_host_model host_u (.power_good_out(power_good_in), .sd_clk_out(sd_clk_in), .sd_cmd_out(sd_cmd_in));
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic [31:0] rst_exp(input int i);
		case (i)
			1: return 32'h0000_0404;
			2: return FEAT_EXP[31:0];
			3: return FEAT_EXP[63:32];
			default: return 32'h0;
		endcase
	endfunction
	// Byte lanes 0 and 1 update a 16-bit register; lanes 2 and 3 carry nothing.
	function logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// The request is held until waitrequest is seen low, so no fixed latency is assumed.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_writedata_in <= wd;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		rd = avs_readdata_out;
		if (n >= 20) begin
			num_errors++;
			finish_test();
		end
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task automatic send(input logic sel, input logic [15:0] a);
		cmd_in <= '{valid: 1'b1, select: sel, addr: a};
		@(posedge ref_clk_in);
		cmd_in.valid <= 1'b0;
		@(posedge ref_clk_in);
		res = addr_result_out;
		@(posedge ref_clk_in);
		res.selected = addr_result_out.selected;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (link_ready_out !== 1'b1 && n < 200);
		check(link_ready_out, 1'b1);
		if (link_ready_out !== 1'b1) begin
			finish_test();
		end
	endtask
	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		#400000;
		num_errors++;
		finish_test();
	end
	initial begin
		seed = 32'hc4ff;
		num_errors = 0;
		cmp_count = 0;
		{avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
		avs_byteenable_in = 4'hf;
		cmd_in = '0;
		rst_in = 1'b1;
		repeat (5) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, 5'(i * 4), 32'h0);
			check(rd, rst_exp(i));
		end
		r32 = xs();
		bus(1'b1, ADDR_FEAT_HI, r32);
		bus(1'b0, ADDR_FEAT_HI, 32'h0);
		check(rd, FEAT_EXP[63:32]);
		dsr = 16'h0404;
		for (int i = 0; i < 6; i++) begin
			r32 = xs();
			avs_byteenable_in <= r32[23:20];
			bus(1'b1, ADDR_DRV_STAGE, r32);
			dsr = merge16(dsr, r32, r32[23:20]);
			avs_byteenable_in <= 4'hf;
			bus(1'b0, ADDR_DRV_STAGE, 32'h0);
			check(rd, {16'h0, dsr});
		end
		check(driver_stage_out, dsr);
		send(1'b1, 16'h0000);
		check(res, 3'b000);
		host_u.power_up(80);
		wait_ready();
		bus(1'b1, ADDR_CONTROL, 32'h1);
		check(addr_published_out, 1'b0);
		r32 = xs();
		addr = r32[31:16] | 16'h0001;
		bus(1'b1, ADDR_REL_ADDR, {16'h0, addr});
		bus(1'b1, ADDR_CONTROL, 32'h1);
		check({addr_published_out, published_addr_out}, {1'b1, addr});
		bus(1'b1, ADDR_REL_ADDR, {16'h0, ~addr});
		bus(1'b0, ADDR_REL_ADDR, 32'h0);
		check(rd, {16'h0, addr});
		send(1'b1, addr ^ 16'h8000);
		check(res, 3'b000);
		send(1'b1, addr);
		check(res, 3'b101);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check(rd, 32'h0000_000f);
		send(1'b1, 16'h0000);
		check(res, 3'b010);
		bus(1'b1, ADDR_CONTROL, 32'h3);
		check(addr_published_out, 1'b0);
		send(1'b1, addr);
		check(res, 3'b000);
		host_u.power_down();
		@(posedge ref_clk_in);
		bus(1'b0, ADDR_REL_ADDR, 32'h0);
		check(rd, 32'h0);
		check({addr_published_out, driver_stage_out}, {1'b0, dsr});
		host_u.power_up(74);
		wait_ready(); // Access after a full power cycle
		check(addr_published_out, 1'b0);
		finish_test();
	end
endmodule
bind card_regs card_regs_assertions chk_u (
	.ref_clk_in          (ref_clk_in),
	.rst_in              (rst_in),
	.avs_address_in      (avs_address_in),
	.avs_read_in         (avs_read_in),
	.avs_write_in        (avs_write_in),
	.avs_readdata_out    (avs_readdata_out),
	.avs_waitrequest_out (avs_waitrequest_out),
	.power_good_in       (power_good_in),
	.cmd_in              (cmd_in),
	.published_addr_out  (published_addr_out),
	.addr_published_out  (addr_published_out),
	.addr_result_out     (addr_result_out),
	.link_ready_out      (link_ready_out),
	.driver_stage_out    (driver_stage_out)
);
